// ===== include/dpscd_map.vh
// constants for the dual pot spi command decoder
`ifndef DPSCD_MAP_VH
`define DPSCD_MAP_VH
`define DPSCD_ADDR_PREFIX 6'h14
`define DPSCD_OP_WRITE_SETTING 4'hc
`define DPSCD_OP_STATUS 4'h5
`define DPSCD_OP_GLOBAL_LOAD 4'h1
`define DPSCD_OP_GLOBAL_STORE 4'h8
`define DPSCD_OP_SINGLE_STORE 4'he
`define DPSCD_OP_SINGLE_LOAD 4'hd
`define DPSCD_OP_STEP 4'h2
`define DPSCD_STATUS_LOW 4'h1
`define DPSCD_WIPER_MAX 6'h3f
`define DPSCD_WIPER_RESET 6'h00
`define DPSCD_WRITE_TIME_NS 5000000
`define DPSCD_CLK_PERIOD_NS 5
`endif

// ===== core/dpscd_sync.v
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
`default_nettype none
module dpscd_sync (
    input wire clk, // sampling clock
    input wire rst, // async reset, high
    input wire din, // asynchronous level
    output reg dout // synchronised level
);
    reg meta;
    // first stage feeds only the second stage
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== core/dpscd_core.v
// spi command decoder of a dual 64-tap digital pot
// What this block does
// [R1] write setting: addr, 1100, index, 0, pot, data byte top two bits zero
// [R2] status read 0101 0001 returns byte with busy flag bit0, bits 7:1 zero
// [R3] global load 0001 index 00 loads both wipers from selected setting
// [R4] global store 1000 index 00 saves both wipers, program after select rises
// [R5] single store 1110 index 0 pot saves one wiper, programs after select rises
// [R6] single load 1101 index 0 pot loads one wiper, no data byte
// [R7] step command 0010 000 pot, then every bit steps the wiper
// [R8] programming starts only after select rises, only for nonvolatile writes; write setting stores its byte at the last data bit
// [R9] step bit high moves wiper up one, low moves down one
// [R10] a store into setting memory lasts at least the write cycle time
// [R11] busy flag shows a running nonvolatile write cycle
// [R12] pot bit picks the pot, two index bits pick one of four settings
// [R13] frame accepted only with prefix 010100 and strap match, else ignored
// [R14] no new nonvolatile write while busy; status still answered
`timescale 1ns/1ps
`default_nettype none
`include "dpscd_map.vh"
module dpscd_core #(
    parameter WRITE_CYCLES = `DPSCD_WRITE_TIME_NS / `DPSCD_CLK_PERIOD_NS // write cycle length
) (
    input wire CLK_SYS, // system clock 200 MHz
    input wire SYS_RST, // async reset, high
    input wire SCK, // spi serial clock pin
    input wire CS_N, // spi chip select pin, low active
    input wire SI, // spi serial data in pin
    output reg SO, // spi serial data out
    output reg SO_OE, // high while driving serial out
    input wire STRAP_ADDRESS_HIGH_BIT, // address strap high
    input wire STRAP_ADDRESS_LOW_BIT, // address strap low
    output wire [5:0] WIPER_POSITION_0, // pot 0 wiper
    output wire [5:0] WIPER_POSITION_1, // pot 1 wiper
    output reg WRITE_IN_PROGRESS_FLAG // nonvolatile write busy
);
    localparam ST_ADDR = 3'd0;
    localparam ST_INSTR = 3'd1;
    localparam ST_DATA = 3'd2;
    localparam ST_STATUS = 3'd3;
    localparam ST_STEP = 3'd4;
    localparam ST_IGNORE = 3'd5;
    localparam ST_DONE = 3'd6;

    wire sck_s, cs_n_s, si_s, cs_sel_s;
    dpscd_sync u_sck (.clk(CLK_SYS), .rst(SYS_RST), .din(SCK), .dout(sck_s));
    // select synced active high: reset leaves it deselected, so no false select rise follows
    dpscd_sync u_cs (.clk(CLK_SYS), .rst(SYS_RST), .din(~CS_N), .dout(cs_sel_s));
    assign cs_n_s = ~cs_sel_s;
    dpscd_sync u_si (.clk(CLK_SYS), .rst(SYS_RST), .din(SI), .dout(si_s));

    reg sck_d, cs_d;
    reg [2:0] state;
    reg [2:0] bit_cnt;
    reg [7:0] shreg;
    reg [7:0] out_sh;
    reg [3:0] opcode;
    reg [1:0] index;
    reg pot;
    reg [5:0] wiper [0:1];
    reg [5:0] setting [0:7];
    reg store_pending;
    reg store_global;
    reg [1:0] store_index;
    reg store_pot;
    reg [31:0] wr_cnt;
    integer i;

    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire cs_rise = cs_n_s & ~cs_d;
    wire [7:0] next_shreg = {shreg[6:0], si_s};
    wire last_bit = (bit_cnt == 3'd7);

    assign WIPER_POSITION_0 = wiper[0];
    assign WIPER_POSITION_1 = wiper[1];

    ////////////////////////////////////////////////////////////////
    // frame decoder on sampled serial clock edges
    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
            state <= ST_ADDR;
            bit_cnt <= 3'd0;
            shreg <= 8'h00;
            out_sh <= 8'h00;
            opcode <= 4'h0;
            index <= 2'd0;
            pot <= 1'b0;
            SO <= 1'b0;
            SO_OE <= 1'b0;
            store_pending <= 1'b0;
            store_global <= 1'b0;
            store_index <= 2'd0;
            store_pot <= 1'b0;
            wiper[0] <= `DPSCD_WIPER_RESET;
            wiper[1] <= `DPSCD_WIPER_RESET;
            for (i = 0; i < 8; i = i + 1) begin
                setting[i] <= `DPSCD_WIPER_RESET;
            end
        end else begin
            sck_d <= sck_s;
            cs_d <= cs_n_s;
            if (cs_n_s) begin
                // deselected: frame ends, output released
                state <= ST_ADDR;
                bit_cnt <= 3'd0;
                SO_OE <= 1'b0;
                SO <= 1'b0;
                if (cs_rise && store_pending) begin
                    store_pending <= 1'b0; // R8
                end
            end else if (sck_rise) begin
                bit_cnt <= bit_cnt + 3'd1;
                shreg <= next_shreg;
                case (state)
                    ST_ADDR: begin
                        if (last_bit) begin
                            // R13
                            if (next_shreg[7:2] == `DPSCD_ADDR_PREFIX &&
                                next_shreg[1:0] == {STRAP_ADDRESS_HIGH_BIT, STRAP_ADDRESS_LOW_BIT}) begin
                                state <= ST_INSTR;
                            end else begin
                                state <= ST_IGNORE;
                            end
                        end
                    end
                    ST_INSTR: begin
                        if (last_bit) begin
                            opcode <= next_shreg[7:4];
                            index <= next_shreg[3:2]; // R12
                            pot <= next_shreg[0]; // R12
                            case (next_shreg[7:4])
                                `DPSCD_OP_STATUS: begin
                                    if (next_shreg[3:0] == `DPSCD_STATUS_LOW) begin
                                        state <= ST_STATUS; // R2
                                        out_sh <= {7'h00, WRITE_IN_PROGRESS_FLAG}; // R2 R11 R14
                                    end else begin
                                        state <= ST_IGNORE;
                                    end
                                end
                                `DPSCD_OP_WRITE_SETTING: state <= ST_DATA; // R1
                                `DPSCD_OP_GLOBAL_LOAD: begin
                                    // R3
                                    wiper[0] <= setting[{1'b0, next_shreg[3:2]}];
                                    wiper[1] <= setting[{1'b1, next_shreg[3:2]}];
                                    state <= ST_DONE;
                                end
                                `DPSCD_OP_SINGLE_LOAD: begin
                                    // R6
                                    wiper[next_shreg[0]] <= setting[{next_shreg[0], next_shreg[3:2]}];
                                    state <= ST_DONE;
                                end
                                `DPSCD_OP_GLOBAL_STORE, `DPSCD_OP_SINGLE_STORE: begin
                                    // R4 R5 R14
                                    if (!WRITE_IN_PROGRESS_FLAG) begin
                                        store_pending <= 1'b1;
                                        store_global <= (next_shreg[7:4] == `DPSCD_OP_GLOBAL_STORE);
                                        store_index <= next_shreg[3:2];
                                        store_pot <= next_shreg[0];
                                    end
                                    state <= ST_DONE;
                                end
                                `DPSCD_OP_STEP: state <= ST_STEP; // R7
                                default: state <= ST_IGNORE;
                            endcase
                        end
                    end
                    ST_DATA: begin
                        if (last_bit) begin
                            // R1 R14: upper bits dropped, setting written now, busy waits for select rise
                            if (!WRITE_IN_PROGRESS_FLAG) begin
                                setting[{pot, index}] <= next_shreg[5:0];
                                store_pending <= 1'b1;
                                store_global <= 1'b0;
                                store_index <= index;
                                store_pot <= pot;
                            end
                            state <= ST_DONE;
                        end
                    end
                    ST_STEP: begin
                        // R9: saturate at the ends of the resistor chain
                        if (si_s && wiper[pot] != `DPSCD_WIPER_MAX) begin
                            wiper[pot] <= wiper[pot] + 6'd1;
                        end else if (!si_s && wiper[pot] != 6'h00) begin
                            wiper[pot] <= wiper[pot] - 6'd1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (sck_fall && state == ST_STATUS) begin
                // status byte shifts out msb first on falling edges
                SO_OE <= 1'b1;
                SO <= out_sh[7];
                out_sh <= {out_sh[6:0], 1'b0};
            end
            // stores copy wipers at select rise; R10 timing below
            if (cs_rise && store_pending && opcode != `DPSCD_OP_WRITE_SETTING) begin
                if (store_global) begin
                    setting[{1'b0, store_index}] <= wiper[0];
                    setting[{1'b1, store_index}] <= wiper[1];
                end else begin
                    setting[{store_pot, store_index}] <= wiper[store_pot];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // write cycle timer; busy flag raised only at select rise
    always @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            wr_cnt <= 32'd0;
            WRITE_IN_PROGRESS_FLAG <= 1'b0;
        end else if (cs_rise && store_pending) begin
            WRITE_IN_PROGRESS_FLAG <= 1'b1; // R8 R11
            wr_cnt <= WRITE_CYCLES - 1;
        end else if (WRITE_IN_PROGRESS_FLAG) begin
            if (wr_cnt == 32'd0) begin
                WRITE_IN_PROGRESS_FLAG <= 1'b0; // R10
            end else begin
                wr_cnt <= wr_cnt - 32'd1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/dpscd_monitor.sv
// port checker for the pot command decoder
`timescale 1ns/1ps
`default_nettype none
module dpscd_monitor #(parameter WRITE_CYCLES = 20) (
    input wire logic CLK_SYS, // clock
    input wire logic SYS_RST, // reset
    input wire logic SCK, // serial clock
    input wire logic CS_N, // select
    input wire logic SI, // data in
    input wire logic SO, // data out
    input wire logic SO_OE, // out enable
    input wire logic STRAP_ADDRESS_HIGH_BIT, // strap
    input wire logic STRAP_ADDRESS_LOW_BIT, // strap
    input wire logic [5:0] WIPER_POSITION_0, // wiper 0
    input wire logic [5:0] WIPER_POSITION_1, // wiper 1
    input wire logic WRITE_IN_PROGRESS_FLAG // busy
);
default clocking @(posedge CLK_SYS); endclocking
default disable iff (SYS_RST);
////////////////////////////////////////////////////////////
// length of the current busy period, so a short write shows
int busy_cnt;
always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST)
        busy_cnt <= 0;
    else
        busy_cnt <= WRITE_IN_PROGRESS_FLAG ? busy_cnt + 1 : 0;
end
////////////////////////////////////////////////////////////
AST_OE_IDLE: assert property (CS_N [*6] |-> !SO_OE) else $error("out enable while deselected");
AST_OE_RISE: assert property ($rose(SO_OE) |-> !CS_N && !SCK) else $error("out enable off edge");
AST_SO_SHIFT: assert property (SO_OE && $past(SO_OE) && $changed(SO) |-> !SCK) else $error("out bit moved");
AST_BUSY_DESEL: assert property ($rose(WRITE_IN_PROGRESS_FLAG) |-> CS_N) else $error("busy inside frame");
AST_BUSY_PROMPT: assert property ($rose(WRITE_IN_PROGRESS_FLAG) |-> !$past(CS_N, 8)) else $error("busy late");
AST_BUSY_LEN: assert property ($fell(WRITE_IN_PROGRESS_FLAG) |-> busy_cnt >= WRITE_CYCLES
    && busy_cnt <= WRITE_CYCLES + 2) else $error("write length wrong");
AST_W0_IDLE: assert property (CS_N [*8] |=> $stable(WIPER_POSITION_0)) else $error("wiper 0 moved idle");
AST_W1_IDLE: assert property (CS_N [*8] |=> $stable(WIPER_POSITION_1)) else $error("wiper 1 moved idle");
CV_STATUS: cover property ($rose(SO_OE));
CV_WRITE: cover property ($fell(WRITE_IN_PROGRESS_FLAG));
CV_STEP: cover property (!CS_N && $changed(WIPER_POSITION_0));
endmodule
`default_nettype wire

// ===== tb/dpscd_host.sv
// spi master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module dpscd_host (
    output logic sck, // serial clock, low between frames
    output logic cs_n, // select, low active
    output logic si, // data to device
    input wire logic so // data from device
);
// idle bus at time zero
initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
end
////////////////////////////////////////////////////////////
// one mode 0 frame, msb first; odd lead-in keeps phase loose
task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] rx);
    rx = 8'h00;
    cs_n <= 1'b0;
    si <= ~si;
    #43;
    for (int i = n - 1; i >= 0; i--) begin
        si <= d[i];
        #32 sck <= 1'b1;
        rx = {rx[6:0], so};
        #32 sck <= 1'b0;
    end
    #40 cs_n <= 1'b1;
    si <= ~si; // released line never shows a stale bit
    #120;
endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the pot command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
localparam int WC = 1000;
logic clk_sys, sys_rst, sck, cs_n, si, so, so_oe, write_in_progress_flag;
logic [5:0] w0, w1;
logic [7:0] rx;
logic so_line;
// undriven serial out shows the inverse, so a late enable corrupts the read
assign so_line = so_oe ? so : ~so;
int n_fail, compares;
// straps fixed at address 2
dpscd_core #(.WRITE_CYCLES(WC)) u_dpscd_core (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SCK(sck), .CS_N(cs_n),
    .SI(si), .SO(so), .SO_OE(so_oe), .STRAP_ADDRESS_HIGH_BIT(1'b1), .STRAP_ADDRESS_LOW_BIT(1'b0),
    .WIPER_POSITION_0(w0), .WIPER_POSITION_1(w1), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag));
dpscd_host u_dpscd_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so_line));
////////////////////////////////////////////////////////////
task chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
        n_fail++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task test_done;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
endtask
// bounded wait on the busy flag; a hang ends the run
task wait_wip(input logic lvl);
    int k;
    k = 0;
    while (write_in_progress_flag !== lvl && k < 2 * WC) begin
        @(posedge clk_sys);
        k++;
    end
    chk({7'h00, write_in_progress_flag}, {7'h00, lvl});
    if (write_in_progress_flag !== lvl) test_done();
endtask
task sframe(input logic [31:0] d, input int n);
    u_dpscd_host.xfer(d, n, rx);
endtask
////////////////////////////////////////////////////////////
task t_setting;
    sframe({8'h52, 4'hc, 2'h2, 1'b0, 1'b1, 8'h2a}, 24);
    wait_wip(1'b1);
    wait_wip(1'b0);
    sframe({8'h52, 4'hd, 2'h2, 1'b0, 1'b1}, 16);
    chk({2'b00, w1}, 8'h2a);
    chk({2'b00, w0}, 8'h00);
    chk({7'h00, write_in_progress_flag}, 8'h00);
    $display("setting write done");
endtask
// second write lands while busy and must be dropped
task t_status;
    sframe({8'h52, 4'hc, 2'h1, 1'b0, 1'b0, 8'h15}, 24);
    sframe({8'h52, 4'hc, 2'h1, 1'b0, 1'b0, 8'h3f}, 24);
    sframe({8'h52, 8'h51, 8'h00}, 24);
    chk(rx, 8'h01);
    wait_wip(1'b0);
    sframe({8'h52, 8'h51, 8'h00}, 24);
    chk(rx, 8'h00);
    sframe({8'h52, 4'hd, 2'h1, 1'b0, 1'b0}, 16);
    chk({2'b00, w0}, 8'h15);
    $display("status done");
endtask
task t_step;
    sframe({8'h52, 8'h20, 6'b111010}, 22);
    chk({2'b00, w0}, 8'h17);
    chk({2'b00, w1}, 8'h2a);
    $display("step done");
endtask
task t_global;
    sframe({8'h52, 4'h8, 2'h3, 2'b00}, 16);
    wait_wip(1'b1);
    wait_wip(1'b0);
    sframe({8'h52, 8'h21, 1'b1}, 17);
    chk({2'b00, w1}, 8'h2b);
    sframe({8'h52, 4'h1, 2'h3, 2'b00}, 16);
    chk({2'b00, w0}, 8'h17);
    chk({2'b00, w1}, 8'h2a);
    chk({7'h00, write_in_progress_flag}, 8'h00);
    $display("global done");
endtask
// foreign address first, then a single store and reload
task t_single;
    sframe({8'h53, 4'hc, 2'h0, 1'b0, 1'b0, 8'h3f}, 24);
    chk({7'h00, write_in_progress_flag}, 8'h00);
    sframe({8'h52, 4'he, 2'h0, 1'b0, 1'b1}, 16);
    wait_wip(1'b1);
    wait_wip(1'b0);
    sframe({8'h52, 8'h21, 1'b0}, 17);
    sframe({8'h52, 4'hd, 2'h0, 1'b0, 1'b1}, 16);
    chk({2'b00, w1}, 8'h2a);
    sframe({8'h52, 4'hd, 2'h0, 1'b0, 1'b0}, 16);
    chk({2'b00, w0}, 8'h00);
    $display("single done");
endtask
////////////////////////////////////////////////////////////
initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
end
// reset, then the scenarios in order
initial begin
    n_fail = 0;
    compares = 0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    t_setting();
    t_status();
    t_step();
    t_global();
    t_single();
    test_done();
end
endmodule
bind dpscd_core dpscd_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_dpscd_monitor (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
    .SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE), .STRAP_ADDRESS_HIGH_BIT(STRAP_ADDRESS_HIGH_BIT),
    .STRAP_ADDRESS_LOW_BIT(STRAP_ADDRESS_LOW_BIT), .WIPER_POSITION_0(WIPER_POSITION_0),
    .WIPER_POSITION_1(WIPER_POSITION_1), .WRITE_IN_PROGRESS_FLAG(WRITE_IN_PROGRESS_FLAG));
`default_nettype wire
